// ==== logic/uart_holding_access_guard.sv ====
// Purpose: holding-register access guard of a serial port, seen from the register port
// Assumes: line framing lives elsewhere and exchanges whole bytes on this clock
// Notes:   a refused access answers with regErr one cycle after the strobe
//          the read answer stands one cycle only and is zero otherwise
//          transmit bytes pass a queue and then an output slot, so a stalled
//          serialiser lets one byte more than the queue depth be accepted
//          interrupt status bits are sticky and cleared by writing a one
//          an unmapped index reads zero and ignores writes, with no error
//          reset asserts at once and releases through two flip-flops
//          host polling and its timeout belong to software

`timescale 1ns/1ps

module uart_holding_access_guard
  import uart_guard_pkg::*;
#(
  parameter int RX_DEPTH = uart_guard_pkg::QDEPTH,
  parameter int TX_DEPTH = uart_guard_pkg::QDEPTH
) (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              resetn,
  // register port
  input  wire logic [uart_guard_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [uart_guard_pkg::DATA_W-1:0] regWrData,
  input  wire logic                              regWr,
  input  wire logic                              regRd,
  output logic      [uart_guard_pkg::DATA_W-1:0] regRdData,
  output logic                                   regErr,
  // received bytes from the line deserialiser
  input  wire logic [uart_guard_pkg::DATA_W-1:0] rxByte,
  input  wire logic                              rxValid,
  // bytes handed to the line serialiser
  output logic      [uart_guard_pkg::DATA_W-1:0] txByte,
  output logic                                   txValid,
  input  wire logic                              txReady,
  // interrupt
  output logic                                   irq
);

  import uart_guard_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [DATA_W-1:0] rdData;
    logic              rdErr;
    logic [DATA_W-1:0] txByte;
    logic              txValid;
    logic [INT_W-1:0]  intStatus;
    logic [INT_W-1:0]  intMask;
    logic              irq;
  } guard_s;

  // all registered state except the reset release flops lives in one struct; the queues keep their own
  guard_s s_reg;
  guard_s s_next;

  // reset release
  logic [1:0]        rstSync_reg;
  logic              rstN;

  // receive queue handshake
  logic              rxPush;
  logic              rxPop;
  logic [DATA_W-1:0] rxHead;
  logic              rxFull;
  logic              rxEmpty;

  // transmit queue handshake
  logic              txPush;
  logic              txPop;
  logic [DATA_W-1:0] txHead;
  logic              txFull;
  logic              txEmpty;

  // decode and status
  logic              dataSel;
  logic              dataRd;
  logic              dataWr;
  logic              statusWr;
  logic [INT_W-1:0]  clearBits;
  logic              rdRefused;
  logic              wrRefused;
  logic              txLoad;
  logic [DATA_W-1:0] lineStatus;
  logic [INT_W-1:0]  events;

  // ************************************************************
  // reset release
  // ************************************************************

  // assert at once, release two edges later so all flops leave reset together
  // only the second flop is read, so a release that lands near an edge
  // cannot reach the logic as a half-taken reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstSync_reg <= 2'b00;
    end else begin
      rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
  end

  assign rstN = rstSync_reg[1];

  // ************************************************************
  // holding queues
  // ************************************************************

  // the line cannot be stalled, so a byte arriving on a full queue is dropped
  assign rxPush = rxValid && !rxFull;

  // receive queue: filled by the deserialiser, drained by data reads
  byte_queue #(
    .WIDTH (DATA_W),
    .DEPTH (RX_DEPTH)
  ) rxQueue (
    .clk      (clk),
    .rstN     (rstN),
    .push     (rxPush),
    .pushData (rxByte),
    .pop      (rxPop),
    .headData (rxHead),
    .full     (rxFull),
    .empty    (rxEmpty),
    .count    ()
  );

  // transmit queue: filled by data writes, drained into the output slot
  byte_queue #(
    .WIDTH (DATA_W),
    .DEPTH (TX_DEPTH)
  ) txQueue (
    .clk      (clk),
    .rstN     (rstN),
    .push     (txPush),
    .pushData (regWrData),
    .pop      (txPop),
    .headData (txHead),
    .full     (txFull),
    .empty    (txEmpty),
    .count    ()
  );

  // ************************************************************
  // access decode
  // ************************************************************

  // refused accesses never reach the queues
  // the queues also ignore such strobes; the refused terms feed the access-error interrupt event
  assign dataSel   = (regAddr == OFF_DATA);
  assign dataRd    = regRd && dataSel;
  assign dataWr    = regWr && dataSel;
  assign rdRefused = dataRd && rxEmpty;
  assign wrRefused = dataWr && txFull;
  assign rxPop     = dataRd && !rxEmpty;
  assign txPush    = dataWr && !txFull;

  // write-one-to-clear: only bits written as one are cleared, and only here
  assign statusWr  = regWr && (regAddr == OFF_INT_STATUS);
  assign clearBits = statusWr ? regWrData[INT_W-1:0] : '0;

  // the output slot refills whenever it is empty or being taken this cycle
  // a registered txByte costs one cycle of latency but keeps the output clean
  assign txLoad = (!s_reg.txValid || txReady) && !txEmpty;
  assign txPop  = txLoad;

  // live line status; reserved bits read as zero
  // bit 6 rises only once the last byte has left the output slot,
  // which is what a host waits for before it shuts the line down
  always_comb begin
    lineStatus                  = '0;
    lineStatus[LS_RX_READY_BIT] = !rxEmpty;
    lineStatus[LS_TX_EMPTY_BIT] = !txFull;
    lineStatus[LS_TX_IDLE_BIT]  = txEmpty && !s_reg.txValid;
  end

  // interrupt events of this cycle
  // overrun: the new byte is lost, the queue keeps the older ones
  // drained: the slot is taken while nothing waits behind it
  always_comb begin
    events                     = '0;
    events[INT_RX_AVAIL_BIT]   = rxPush;
    events[INT_RX_OVERRUN_BIT] = rxValid && rxFull;
    events[INT_ACCESS_ERR_BIT] = rdRefused || wrRefused;
    events[INT_TX_DRAINED_BIT] = s_reg.txValid && txReady && txEmpty;
  end

  // ************************************************************
  // next state
  // ************************************************************

  // read answer, register writes, output slot and interrupt in one pass
  always_comb begin
    s_next        = s_reg;
    s_next.rdData = RD_DATA_RESET;
    s_next.rdErr  = 1'b0;

    // reads: answer stands only in the cycle after the strobe
    // a refused read answers zero beside the error bit and pops nothing
    if (regRd) begin
      case (regAddr)
        OFF_DATA: begin
          if (rxEmpty) begin
            s_next.rdErr = 1'b1;
          end else begin
            s_next.rdData = rxHead;
          end
        end
        OFF_LINE_STATUS: begin
          s_next.rdData = lineStatus;
        end
        OFF_INT_STATUS: begin
          s_next.rdData = {{(DATA_W - INT_W){1'b0}}, s_reg.intStatus};
        end
        OFF_INT_MASK: begin
          s_next.rdData = {{(DATA_W - INT_W){1'b0}}, s_reg.intMask};
        end
        default: begin
          s_next.rdData = RD_DATA_RESET;
        end
      endcase
    end

    // writes: line status is read only and ignores writes
    // a refused write stores nothing; regErr and the access-error status bit are its only trace
    if (regWr) begin
      case (regAddr)
        OFF_DATA: begin
          s_next.rdErr = txFull;
        end
        OFF_INT_STATUS: begin
          s_next.intStatus = s_reg.intStatus & ~clearBits;
        end
        OFF_INT_MASK: begin
          s_next.intMask = regWrData[INT_W-1:0];
        end
        default: begin
          s_next.rdErr = 1'b0;
        end
      endcase
    end

    // a new event beats a clear written in the same cycle
    s_next.intStatus = s_next.intStatus | events;

    // output slot toward the serialiser
    // a stalled serialiser keeps the slot full and the byte steady
    if (txLoad) begin
      s_next.txByte  = txHead;
      s_next.txValid = 1'b1;
    end else if (txReady) begin
      s_next.txValid = 1'b0;
    end

    // irq is built from the next status and mask, one cycle after its cause
    s_next.irq = |(s_next.intStatus & s_next.intMask);
  end

  // ************************************************************
  // registers
  // ************************************************************

  // fields reset one by one; data, status and mask to their own named values, the flags to zero
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_reg.rdData    <= RD_DATA_RESET;
      s_reg.rdErr     <= 1'b0;
      s_reg.txByte    <= TX_BYTE_RESET;
      s_reg.txValid   <= 1'b0;
      s_reg.intStatus <= INT_STATUS_RESET;
      s_reg.intMask   <= INT_MASK_RESET;
      s_reg.irq       <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************

  // every output is a flip-flop of the state struct
  // regErr carries the error flag of refused reads and refused writes alike
  assign regRdData = s_reg.rdData;
  assign regErr    = s_reg.rdErr;
  assign txByte    = s_reg.txByte;
  assign txValid   = s_reg.txValid;
  assign irq       = s_reg.irq;

endmodule

// ==== logic/uart_guard_pkg.sv ====
// Purpose: shared constants for the serial port holding-register access guard
// Assumes: byte-wide register port, one clock domain
// Notes:   offsets are register indices on the plain register port

package uart_guard_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 4;
  localparam int INT_W   = 4;
  localparam int QDEPTH  = 16;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFF_DATA        = 4'h0; // receive read / transmit write
  localparam logic [ADDR_W-1:0] OFF_LINE_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_INT_STATUS  = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK    = 4'h3;

  // ************************************************************
  // line status fields
  // ************************************************************
  localparam int LS_RX_READY_BIT = 0;
  localparam int LS_TX_EMPTY_BIT = 5;
  localparam int LS_TX_IDLE_BIT  = 6;

  // ************************************************************
  // interrupt status and mask fields
  // ************************************************************
  localparam int INT_RX_AVAIL_BIT   = 0;
  localparam int INT_RX_OVERRUN_BIT = 1;
  localparam int INT_ACCESS_ERR_BIT = 2;
  localparam int INT_TX_DRAINED_BIT = 3;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [INT_W-1:0]  INT_STATUS_RESET = 4'h0;
  localparam logic [INT_W-1:0]  INT_MASK_RESET   = 4'h0;
  localparam logic [DATA_W-1:0] RD_DATA_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] TX_BYTE_RESET    = 8'h00;

endpackage

// ==== logic/byte_queue.sv ====
// Purpose: flip-flop queue used for the receive and transmit holding paths
// Assumes: push and pop come from logic on the same clock
// Notes:   push when full and pop when empty are ignored, nothing moves

`timescale 1ns/1ps

module byte_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rstN,
  // fill side
  input  wire logic                       push,
  input  wire logic [WIDTH-1:0]           pushData,
  // drain side
  input  wire logic                       pop,
  output logic      [WIDTH-1:0]           headData,
  // fill state
  output logic                            full,
  output logic                            empty,
  output logic      [$clog2(DEPTH+1)-1:0] count
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [CW-1:0]               count;
  } queue_s;

  queue_s q_reg;
  queue_s q_next;
  logic   doPush;
  logic   doPop;

  // guarded strobes: a refused access leaves pointers and storage alone
  assign full     = (q_reg.count == CW'(DEPTH));
  assign empty    = (q_reg.count == '0);
  assign count    = q_reg.count;
  assign headData = q_reg.mem[q_reg.rdPtr];
  assign doPush   = push && !full;
  assign doPop    = pop && !empty;

  // next state: write at tail, advance head, keep the count
  always_comb begin
    q_next = q_reg;
    if (doPush) begin
      q_next.mem[q_reg.wrPtr] = pushData;
      q_next.wrPtr = (q_reg.wrPtr == AW'(DEPTH - 1)) ? '0 : q_reg.wrPtr + 1'b1;
    end
    if (doPop) begin
      q_next.rdPtr = (q_reg.rdPtr == AW'(DEPTH - 1)) ? '0 : q_reg.rdPtr + 1'b1;
    end
    if (doPush && !doPop) begin
      q_next.count = q_reg.count + 1'b1;
    end else if (doPop && !doPush) begin
      q_next.count = q_reg.count - 1'b1;
    end
  end

  // storage is cleared too, so a stale head never reads as unknown
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

endmodule

// ==== bench/uart_guard_props.sv ====
// Purpose: port-level checks for the holding-register access guard
// Assumes: occupancy is modelled from the ports; the tx output slot is txValid
// Notes:   pushes into a full queue and pops of an empty one are not counted
`timescale 1ns/1ps
module uart_guard_props
  import uart_guard_pkg::*;
#(
  parameter int RX_DEPTH = 16,
  parameter int TX_DEPTH = 16
) (
  // clock and reset
  input wire logic                              clk,
  input wire logic                              resetn,
  // register port
  input wire logic [uart_guard_pkg::ADDR_W-1:0] regAddr,
  input wire logic                              regWr,
  input wire logic                              regRd,
  input wire logic [uart_guard_pkg::DATA_W-1:0] regRdData,
  input wire logic                              regErr,
  // line side
  input wire logic                              rxValid,
  input wire logic [uart_guard_pkg::DATA_W-1:0] txByte,
  input wire logic                              txValid,
  input wire logic                              txReady
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [5:0] rxCnt;
  logic [5:0] txCnt;
  wire rdData = regRd && regAddr == OFF_DATA;
  wire wrData = regWr && regAddr == OFF_DATA;
  wire rdLine = regRd && regAddr == OFF_LINE_STATUS;
  wire txLoad = txCnt != 0 && (!txValid || txReady);
  // queue fill as the host sees it; a refused access moves nothing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxCnt <= '0;
      txCnt <= '0;
    end else begin
      rxCnt <= rxCnt + 6'(rxValid && rxCnt < RX_DEPTH) - 6'(rdData && rxCnt != 0);
      txCnt <= txCnt + 6'(wrData && txCnt < TX_DEPTH) - 6'(txLoad);
    end
  end
  property p_rx_empty; rdData && rxCnt == 0 |=> regErr && regRdData == '0; endproperty
  a_rx_empty: assert property (p_rx_empty) else $error("empty read not refused");
  property p_rx_ok; rdData && rxCnt != 0 |=> !regErr; endproperty
  a_rx_ok: assert property (p_rx_ok) else $error("good read refused");
  property p_rx_flag; rdLine |=> regRdData[0] == ($past(rxCnt) != 0); endproperty
  a_rx_flag: assert property (p_rx_flag) else $error("ready flag wrong");
  property p_tx_flag; rdLine |=> regRdData[5] == ($past(txCnt) < TX_DEPTH); endproperty
  a_tx_flag: assert property (p_tx_flag) else $error("space flag wrong");
  property p_tx_full; wrData && txCnt == TX_DEPTH |=> regErr; endproperty
  a_tx_full: assert property (p_tx_full) else $error("full write not refused");
  property p_tx_ok; wrData && txCnt < TX_DEPTH |=> !regErr; endproperty
  a_tx_ok: assert property (p_tx_ok) else $error("good write refused");
  property p_hold; wrData && txCnt == TX_DEPTH && txValid && !txReady |=> txValid && $stable(txByte);
  endproperty
  a_hold: assert property (p_hold) else $error("refused write moved tx");
  property p_cause; regErr |-> $past(regRd || regWr) && $past(regAddr) == OFF_DATA; endproperty
  a_cause: assert property (p_cause) else $error("error without data access");
endmodule
bind uart_holding_access_guard uart_guard_props #(.RX_DEPTH(RX_DEPTH), .TX_DEPTH(TX_DEPTH))
  u_uart_guard_props (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWr(regWr),
  .regRd(regRd), .regRdData(regRdData), .regErr(regErr), .rxValid(rxValid),
  .txByte(txByte), .txValid(txValid), .txReady(txReady));

// ==== bench/line_side_model.sv ====
// Purpose: stand-in for the line deserialiser and serialiser
// Assumes: same clock as the guard
// Notes:   idle rxByte shows the inverse of the last byte so stale data never matches
`timescale 1ns/1ps
module line_side_model (
  // control and clock
  input wire logic        clk,
  input wire logic        stall,
  // serialiser side
  input wire logic [7:0]  txByte,
  input wire logic        txValid,
  output logic            txReady,
  // deserialiser side
  output logic     [7:0]  rxByte,
  output logic            rxValid
);
  logic [7:0] seen[$];
  initial begin
    rxValid = 1'b0;
    rxByte = 8'h00;
    txReady = 1'b0;
  end
  // collect bytes handed over; stall holds the guard back
  always @(posedge clk) begin
    if (txValid && txReady) seen.push_back(txByte);
    txReady <= !stall;
  end
  // one received byte, one cycle long; it cannot be held off
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    rxByte <= b;
    rxValid <= 1'b1;
    @(posedge clk);
    rxValid <= 1'b0;
    rxByte <= ~b;
  endtask
endmodule

// ==== bench/tb_top.sv ====
// Purpose: register-level test of the holding-register access guard
// Assumes: depth 16 queues, one strobe per access with a gap between
// Notes:   host tasks poll the line status first, as software must
`timescale 1ns/1ps
module tb_top;
  import uart_guard_pkg::*;
  logic clk = 0, resetn = 0, regWr = 0, regRd = 0, stall = 1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic [DATA_W-1:0] regRdData, rxByte, txByte, got;
  logic txValid, txReady, rxValid, regErr, irq;
  int bad_count = 0, checks_done = 0, cycles = 0;
  always #25 clk = ~clk;
  uart_holding_access_guard u_uart_holding_access_guard (.clk(clk), .resetn(resetn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .regErr(regErr), .rxByte(rxByte), .rxValid(rxValid),
    .txByte(txByte), .txValid(txValid), .txReady(txReady), .irq(irq));
  line_side_model u_line_side_model (.clk(clk), .stall(stall), .txByte(txByte),
    .txValid(txValid), .txReady(txReady), .rxByte(rxByte), .rxValid(rxValid));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] g, input logic [7:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // one access; the answer is sampled mid-cycle, the only cycle it stands
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, input logic e);
    regWr <= w;
    regRd <= !w;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    @(negedge clk);
    got = regRdData;
    check({7'h0, regErr}, {7'h0, e}, "error answer");
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input logic r);
    acc(1'b0, a, 8'h00, r);
    check(got & m, e, "read data");
  endtask
  // host receive: data is read only when the ready flag says so
  task automatic host_rx(input logic [7:0] e);
    acc(1'b0, OFF_LINE_STATUS, 8'h00, 1'b0);
    check(got & 8'h01, 8'h01, "ready flag");
    if (got[LS_RX_READY_BIT]) begin
      acc(1'b0, OFF_DATA, 8'h00, 1'b0);
      check(got, e, "received byte");
    end
  endtask
  // host transmit: bounded poll so a stuck port cannot hang software
  task automatic host_tx(input logic [7:0] b);
    for (int i = 0; i < 20; i++) begin
      acc(1'b0, OFF_LINE_STATUS, 8'h00, 1'b0);
      if (got[LS_TX_EMPTY_BIT]) break;
    end
    check(got & 8'h20, 8'h20, "space flag");
    if (got[LS_TX_EMPTY_BIT]) acc(1'b1, OFF_DATA, b, 1'b0);
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      stop_test;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(OFF_LINE_STATUS, 8'hff, 8'h60, 1'b0);
    rd(OFF_DATA, 8'hff, 8'h00, 1'b1);
    rd(OFF_LINE_STATUS, 8'hff, 8'h60, 1'b0);
    rd(4'h9, 8'hff, 8'h00, 1'b0);
    rd(OFF_INT_STATUS, 8'h04, 8'h04, 1'b0);
    @(negedge clk);
    check({7'h0, irq}, 8'h00, "irq while masked");
    @(posedge clk);
    acc(1'b1, OFF_INT_MASK, 8'h04, 1'b0);
    @(negedge clk);
    check({7'h0, irq}, 8'h01, "irq raised");
    @(posedge clk);
    acc(1'b1, OFF_INT_STATUS, 8'h04, 1'b0);
    @(negedge clk);
    check({7'h0, irq}, 8'h00, "irq cleared");
    u_line_side_model.send(8'ha5);
    u_line_side_model.send(8'h3c);
    host_rx(8'ha5);
    host_rx(8'h3c);
    rd(OFF_LINE_STATUS, 8'h01, 8'h00, 1'b0);
    for (int i = 0; i < 17; i++) host_tx(8'(8'h10 + i));
    rd(OFF_LINE_STATUS, 8'h20, 8'h00, 1'b0);
    acc(1'b1, OFF_DATA, 8'hee, 1'b1);
    rd(OFF_LINE_STATUS, 8'h20, 8'h00, 1'b0);
    stall <= 1'b0;
    for (int i = 0; i < 100 && u_line_side_model.seen.size() < 17; i++) @(posedge clk);
    check(8'(u_line_side_model.seen.size()), 8'h11, "tx count");
    for (int i = 0; i < 17; i++) check(u_line_side_model.seen[i], 8'(8'h10 + i), "tx byte");
    rd(OFF_LINE_STATUS, 8'h60, 8'h60, 1'b0);
    rd(OFF_INT_STATUS, 8'h0f, 8'h0d, 1'b0);
    stop_test;
  end
endmodule
